// ---- kbu_regs.vh ----
// kbu_regs.vh: register map, field positions and reset values of the keyboard interrupt unit
// assumes a 32-bit avalon-mm slave with word addresses (byte address / 4)
`ifndef KBU_REGS_VH
`define KBU_REGS_VH

// word addresses
`define KBU_ADDR_SC 3'h0
`define KBU_ADDR_PE 3'h1
`define KBU_ADDR_PULL 3'h2
`define KBU_ADDR_DIR 3'h3
`define KBU_ADDR_ANA 3'h4
`define KBU_ADDR_PIN 3'h5
`define KBU_ADDR_IRQ_STAT 3'h6
`define KBU_ADDR_IRQ_EN 3'h7
`define KBU_ADDR_IRQ_CLR 4'h8
`define KBU_ADDR_W 4

// status/control fields
`define KBU_SC_MOD 0
`define KBU_SC_IE 1
`define KBU_SC_ACK 2
`define KBU_SC_FLAG 3
`define KBU_SC_POL_LO 4
`define KBU_SC_POL_HI 7

// status-register event bits
`define KBU_EV_FLAG 0
`define KBU_EV_WAKE 1
`define KBU_EV_W 2

`define KBU_NPIN 8
`define KBU_NPOL 4
`define KBU_NANA 3
`define KBU_RST8 8'h00
`define KBU_RST4 4'h0
`define KBU_RST2 2'h0
`define KBU_RST3 3'h0

`endif

// ---- kbu_sync.v ----
// kbu_sync.v: two-flop synchroniser, one per bit, for the pin levels
// assumes asynchronous pin inputs and the bus clock
`timescale 1ns/1ps
module kbu_sync
(
  input wire clk,
  input wire nrst,
  input wire [7:0] din,
  output wire [7:0] dout
);
  reg [7:0] meta_q;
  reg [7:0] sync_q;

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_q <= 8'h00;
      sync_q <= 8'h00;
    end
    else
    begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule

// ---- kbu_top.v ----
// kbu_top.v: eight-input keyboard interrupt unit with pin sharing, pull steering and wake
// assumes an avalon-mm master on CLK, asynchronous pins, a low-power controller reading WAKE
// Functional notes
// - eight keyboard inputs, each shared with a general-purpose port pin
// - inputs 3:0 falling/low only; inputs 7:4 polarity set by select bits
// - keyboard-enabled pin is forced to input whatever its direction bit says
// - keyboard pin level stays readable in port data when direction bit is 0
// - analog-enabled pin drops port and keyboard function and its pull resistor
// - pull enable with rising polarity gives pulldown, falling gives pullup
// - polarity bits 7:4 pick falling(0) or rising(1), only on enabled pins
// - read-only flag bit 3 sets on a trigger event on any enabled input
// - writing 1 to acknowledge bit 2 clears flag; bit reads as 0
// - edge-and-level mode keeps setting flag while any input is asserted
// - enable bit 1 gates flag onto the interrupt; flag still pollable
// - mode bit: 0 edge-only, 1 edge-and-level, for all inputs
// - a pending event wakes the device from deep sleep or wait
// - edges found by sampling one bus cycle against the next
// - in both modes an edge counts only when all enabled pins were deasserted the cycle before
// - in deep sleep enabled inputs are synchronised level wake sources
// - enable bit 1 links pin to keyboard logic; 0 leaves plain port
`timescale 1ns/1ps
`include "kbu_regs.vh"
module kbu_top
(
  input wire CLK,
  input wire NRST,
  input wire [3:0] ADDRESS,
  input wire READ,
  input wire WRITE,
  input wire [31:0] WRITEDATA,
  output reg [31:0] READDATA,
  output reg WAITREQUEST,
  input wire [7:0] PIN_IN,
  output reg [7:0] PIN_OUT,
  output reg [7:0] PIN_OE,
  output reg [7:0] PULLUP_EN,
  output reg [7:0] PULLDOWN_EN,
  input wire DEEP_SLEEP,
  input wire WAIT_MODE,
  output reg IRQ,
  output reg WAKE
);
  ////////////////////////////////////////////////////////////////////////////
  // registers
  reg [3:0] pol_q;
  reg ie_q;
  reg mod_q;
  reg flag_q;
  reg [7:0] pe_q;
  reg [7:0] pull_q;
  reg [7:0] dir_q;
  reg [7:0] dout_q;
  reg [2:0] ana_q;
  reg [1:0] ist_q;
  reg [1:0] ien_q;
  reg [7:0] prev_q;
  reg ack_q;
  wire [7:0] pin_s;
  wire [7:0] pol_full;
  wire [7:0] ana_full;
  wire [7:0] kb_en;
  wire [7:0] asserted;
  wire [7:0] was_asserted;
  wire edge_ev;
  wire any_level;
  wire set_flag;
  wire acc;
  wire wr;
  wire [7:0] wake_lvl;
  wire wake_pend;
  wire [7:0] port_rd;
  wire wake_d;

  kbu_sync u_sync
  (
    .clk(CLK),
    .nrst(NRST),
    .din(PIN_IN),
    .dout(pin_s)
  );

  assign pol_full = {pol_q, `KBU_RST4};
  assign ana_full = {ana_q, `KBU_RST3, 2'h0}; // analog on pins 7,6,5
  assign kb_en = pe_q & ~ana_full;
  assign asserted = kb_en & ~(pin_s ^ pol_full);
  assign was_asserted = kb_en & ~(prev_q ^ pol_full);
  assign any_level = |asserted;

  ////////////////////////////////////////////////////////////////////////////
  // per-pin port, pull and direction steering
  genvar i;
  generate
    for (i = 0; i < `KBU_NPIN; i = i + 1)
    begin : g_pin
      always @(posedge CLK or negedge NRST)
      begin
        if (!NRST)
        begin
          PIN_OE[i] <= 1'b0;
          PIN_OUT[i] <= 1'b0;
          PULLUP_EN[i] <= 1'b0;
          PULLDOWN_EN[i] <= 1'b0;
        end
        else
        begin
          PIN_OE[i] <= dir_q[i] & ~pe_q[i] & ~ana_full[i];
          PIN_OUT[i] <= dout_q[i];
          PULLUP_EN[i] <= pull_q[i] & ~ana_full[i] & (pe_q[i] ? ~pol_full[i] : ~dir_q[i]);
          PULLDOWN_EN[i] <= pull_q[i] & ~ana_full[i] & pe_q[i] & pol_full[i];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // event detection
  // edge: some newly asserted while none was asserted before
  assign edge_ev = (|(asserted & ~was_asserted)) & ~(|was_asserted);
  assign set_flag = edge_ev | (mod_q & any_level);

  assign acc = (READ | WRITE) & WAITREQUEST;
  assign wr = WRITE & WAITREQUEST;

  always @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      prev_q <= `KBU_RST8;
    else
      prev_q <= pin_s;
  end

  // flag: set wins over acknowledge
  always @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      flag_q <= 1'b0;
    else if (set_flag)
      flag_q <= 1'b1;
    else if (ack_q)
      flag_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: one wait cycle, access completes on the second edge
  always @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      WAITREQUEST <= 1'b1;
    else
      WAITREQUEST <= ~((READ | WRITE) & WAITREQUEST);
  end

  always @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      pol_q <= `KBU_RST4;
      ie_q <= 1'b0;
      mod_q <= 1'b0;
      pe_q <= `KBU_RST8;
      pull_q <= `KBU_RST8;
      dir_q <= `KBU_RST8;
      dout_q <= `KBU_RST8;
      ana_q <= `KBU_RST3;
      ien_q <= `KBU_RST2;
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= wr && ADDRESS == {1'b0, `KBU_ADDR_SC} && WRITEDATA[`KBU_SC_ACK];
      if (wr)
      begin
        case (ADDRESS)
          {1'b0, `KBU_ADDR_SC}:
          begin
            pol_q <= WRITEDATA[`KBU_SC_POL_HI:`KBU_SC_POL_LO];
            ie_q <= WRITEDATA[`KBU_SC_IE];
            mod_q <= WRITEDATA[`KBU_SC_MOD];
          end
          {1'b0, `KBU_ADDR_PE}: pe_q <= WRITEDATA[7:0];
          {1'b0, `KBU_ADDR_PULL}: pull_q <= WRITEDATA[7:0];
          {1'b0, `KBU_ADDR_DIR}: dir_q <= WRITEDATA[7:0];
          {1'b0, `KBU_ADDR_PIN}: dout_q <= WRITEDATA[7:0];
          {1'b0, `KBU_ADDR_ANA}: ana_q <= WRITEDATA[2:0];
          {1'b0, `KBU_ADDR_IRQ_EN}: ien_q <= WRITEDATA[1:0];
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky interrupt status: set wins over clear
  genvar e;
  wire [1:0] ev = {wake_d, set_flag};
  generate
    for (e = 0; e < `KBU_EV_W; e = e + 1)
    begin : g_ev
      always @(posedge CLK or negedge NRST)
      begin
        if (!NRST)
          ist_q[e] <= 1'b0;
        else if (ev[e])
          ist_q[e] <= 1'b1;
        else if (wr && ADDRESS == `KBU_ADDR_IRQ_CLR && WRITEDATA[e])
          ist_q[e] <= 1'b0;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read data
  // direction-0 pins read their level, outputs the latch; keyboard pins with direction 1 and analog pins read 0
  assign port_rd = ~ana_full & ((dir_q & ~pe_q & dout_q) | (~dir_q & pin_s));

  always @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      READDATA <= 32'h0;
    else if (acc && READ)
    begin
      case (ADDRESS)
        {1'b0, `KBU_ADDR_SC}: READDATA <= {24'h0, pol_q, flag_q, 1'b0, ie_q, mod_q};
        {1'b0, `KBU_ADDR_PE}: READDATA <= {24'h0, pe_q};
        {1'b0, `KBU_ADDR_PULL}: READDATA <= {24'h0, pull_q};
        {1'b0, `KBU_ADDR_DIR}: READDATA <= {24'h0, dir_q};
        {1'b0, `KBU_ADDR_ANA}: READDATA <= {29'h0, ana_q};
        {1'b0, `KBU_ADDR_PIN}: READDATA <= {24'h0, port_rd};
        {1'b0, `KBU_ADDR_IRQ_STAT}: READDATA <= {30'h0, ist_q};
        {1'b0, `KBU_ADDR_IRQ_EN}: READDATA <= {30'h0, ien_q};
        default: READDATA <= 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt and wake
  // a pending flag wakes the device from wait or deep sleep
  assign wake_pend = flag_q & (WAIT_MODE | DEEP_SLEEP);
  // in deep sleep the edge logic is bypassed and any enabled pin at its asserted level wakes;
  // the synchronised level is used so that no raw pin reaches a flop
  assign wake_lvl = asserted & {`KBU_NPIN{DEEP_SLEEP}};
  assign wake_d = wake_pend | (|wake_lvl);

  always @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      IRQ <= 1'b0;
      WAKE <= 1'b0;
    end
    else
    begin
      IRQ <= (flag_q & ie_q) | (|(ist_q & ien_q));
      WAKE <= wake_d;
    end
  end
endmodule

// ---- kbu_chk_asserts.sv ----
// kbu_chk_asserts.sv: port checker for the keyboard interrupt unit
// assumes it is bound onto kbu_top
`timescale 1ns/1ps
module kbu_chk
(
  input wire CLK,
  input wire NRST,
  input wire [3:0] ADDRESS,
  input wire READ,
  input wire WRITE,
  input wire [31:0] READDATA,
  input wire WAITREQUEST,
  input wire [7:0] PIN_OUT,
  input wire [7:0] PIN_OE,
  input wire [7:0] PULLUP_EN,
  input wire [7:0] PULLDOWN_EN,
  input wire IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  wire done = READ && !WAITREQUEST;
  ////////////////////////////////////////////////////////////////
  a_wait_one: assert property ((READ || WRITE) && WAITREQUEST |=> !WAITREQUEST) else $error("no answer");
  a_wait_back: assert property (!WAITREQUEST |=> WAITREQUEST) else $error("wait low too long");
  a_ack_zero: assert property (done && ADDRESS == 4'h0 |-> !READDATA[2]) else $error("ack reads 1");
  a_unmapped_zero: assert property (done && ADDRESS > 4'h8 |-> READDATA == 32'h0) else $error("unmapped data");
  a_pull_oe: assert property ((PIN_OE & (PULLUP_EN | PULLDOWN_EN)) == 8'h0) else $error("pull on output");
  a_pull_one: assert property ((PULLUP_EN & PULLDOWN_EN) == 8'h0) else $error("pull both");
  a_pin_cfg: assert property (
    !$stable({PIN_OUT, PIN_OE, PULLUP_EN, PULLDOWN_EN}) |-> $past(WRITE) || $past(WRITE, 2))
    else $error("pin change without write");
  a_irq_fall: assert property (
    $fell(IRQ) |-> $past(WRITE) || $past(WRITE, 2) || $past(WRITE, 3))
    else $error("irq fell alone");
  a_rst_quiet: assert property (
    disable iff (1'b0) !NRST |-> !IRQ && WAITREQUEST && PIN_OE == 8'h0)
    else $error("reset outputs");
endmodule
bind kbu_top kbu_chk i_kbu_chk
(
  .CLK(CLK),
  .NRST(NRST),
  .ADDRESS(ADDRESS),
  .READ(READ),
  .WRITE(WRITE),
  .READDATA(READDATA),
  .WAITREQUEST(WAITREQUEST),
  .PIN_OUT(PIN_OUT),
  .PIN_OE(PIN_OE),
  .PULLUP_EN(PULLUP_EN),
  .PULLDOWN_EN(PULLDOWN_EN),
  .IRQ(IRQ)
);

// ---- kbu_keys.sv ----
// kbu_keys.sv: key switches and signal sources on the eight pins
// assumes the bench picks which pins an external source drives
`timescale 1ns/1ps
module kbu_keys
(
  input wire clk,
  input wire [7:0] drv_en,
  input wire [7:0] drv_val,
  input wire [7:0] pin_out,
  input wire [7:0] pin_oe,
  input wire [7:0] pullup_en,
  input wire [7:0] pulldown_en,
  output logic [7:0] pin_in
);
  logic [7:0] flt_q = 8'h00;
  always @(posedge clk) flt_q <= ~flt_q;
  // device driver, then source, then pull, else a floating pattern
  always_comb
    for (int i = 0; i < 8; i++)
      pin_in[i] = pin_oe[i] ? pin_out[i] : drv_en[i] ? drv_val[i] : pullup_en[i] | (~pulldown_en[i] & flt_q[i]);
endmodule

// ---- tb_top.sv ----
// tb_top.sv: scenario bench for kbu_top
// assumes kbu_keys on the pins and the bound checker
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b1;
  logic rd = 1'b0, wr = 1'b0, sleep = 1'b0, wmode = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic wreq, irq, wake;
  logic [7:0] pin_in, pin_out, pin_oe, pu, pd, drv_en = 8'h00, drv_val = 8'h00;
  int num_errors = 0, compares = 0, cycles = 0;
  kbu_top i_kbu_top (.CLK(clk), .NRST(nrst), .ADDRESS(addr), .READ(rd), .WRITE(wr), .WRITEDATA(wdata),
    .READDATA(rdata), .WAITREQUEST(wreq), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PULLUP_EN(pu),
    .PULLDOWN_EN(pd), .DEEP_SLEEP(sleep), .WAIT_MODE(wmode), .IRQ(irq), .WAKE(wake));
  kbu_keys i_kbu_keys (.clk(clk), .drv_en(drv_en), .drv_val(drv_val), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_en(pu), .pulldown_en(pd), .pin_in(pin_in));
  initial forever #10 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  task automatic finish_test;
    if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk)
    if (++cycles > 3000)
    begin
      num_errors++;
      finish_test;
    end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do @(posedge clk); while (wreq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rc(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk({pin_oe, pu, pd}, 32'h0);
    for (int a = 0; a < 10; a++)
      if (a != 5 && a != 8) rc(a[3:0], 32'h0);
  endtask
  task automatic t_edge;
    bus(1'b1, 4'h2, 32'h1);
    bus(1'b1, 4'h1, 32'h1);
    drv_en <= 8'h01;
    idle(5);
    rc(4'h0, 32'h8);
    chk(irq, 32'h0);
    rc(4'h6, 32'h1);
    bus(1'b1, 4'h7, 32'h1);
    idle(2);
    chk(irq, 32'h1);
    bus(1'b1, 4'h8, 32'h3);
    idle(2);
    chk(irq, 32'h0);
    bus(1'b1, 4'h0, 32'h2);
    idle(2);
    chk(irq, 32'h1);
    bus(1'b1, 4'h0, 32'h6);
    idle(2);
    chk(irq, 32'h0);
    rc(4'h0, 32'h2);
  endtask
  task automatic t_level;
    bus(1'b1, 4'h0, 32'h7);
    idle(3);
    rc(4'h0, 32'hb);
    drv_en <= 8'h00;
    idle(5);
    bus(1'b1, 4'h0, 32'h5);
    rc(4'h0, 32'h1);
    bus(1'b1, 4'h8, 32'h3);
  endtask
  task automatic t_pol;
    bus(1'b1, 4'h0, 32'h10);
    bus(1'b1, 4'h2, 32'h11);
    bus(1'b1, 4'h1, 32'h11);
    idle(3);
    chk({pu, pd}, 32'h0110);
    drv_en <= 8'h10;
    drv_val <= 8'h10;
    idle(5);
    rc(4'h0, 32'h18);
  endtask
  task automatic t_port;
    bus(1'b1, 4'h1, 32'h0);
    bus(1'b1, 4'h3, 32'h80);
    bus(1'b1, 4'h5, 32'h80);
    idle(3);
    chk({pin_oe[7], pin_out[7]}, 32'h3);
    bus(1'b1, 4'h1, 32'h80);
    idle(3);
    chk(pin_oe[7], 32'h0);
    bus(1'b1, 4'h3, 32'h0);
    drv_en <= 8'h80;
    drv_val <= 8'h80;
    idle(4);
    bus(1'b0, 4'h5, 32'h0);
    chk(rdata[7], 32'h1);
    drv_val <= 8'h00;
    idle(4);
    bus(1'b0, 4'h5, 32'h0);
    chk(rdata[7], 32'h0);
    bus(1'b1, 4'h2, 32'h80);
    bus(1'b1, 4'h4, 32'h4);
    idle(3);
    chk({pin_oe[7], pu[7], pd[7]}, 32'h0);
  endtask
  // pin 7 stays low while it is re-enabled, so only a level can wake
  task automatic t_wake;
    bus(1'b1, 4'h4, 32'h0);
    bus(1'b1, 4'h0, 32'h14);
    idle(4);
    rc(4'h0, 32'h10);
    chk(wake, 32'h0);
    sleep <= 1'b1;
    idle(3);
    chk(wake, 32'h1);
    sleep <= 1'b0;
    drv_val <= 8'h80;
    idle(5);
    drv_val <= 8'h00;
    idle(5);
    drv_val <= 8'h80;
    idle(5);
    chk(wake, 32'h0);
    wmode <= 1'b1;
    idle(3);
    chk(wake, 32'h1);
    wmode <= 1'b0;
  endtask
  initial
  begin
    nrst <= 1'b0;
    idle(3);
    nrst <= 1'b1;
    t_reset;
    t_edge;
    t_level;
    t_pol;
    t_port;
    t_wake;
    finish_test;
  end
endmodule
